// file: core/hist_pkg.sv
// register map, field layout and reset values of the hdlc interrupt and status block
// Overview of operation
// - window writes store byte, pointer auto-increments
// - interrupt status at 0x20, reset zero
// - receive message end on frame end
// - receive pool full on 32-byte block
// - remote state change in auto-mode only
// - transmit pool ready in three cases
// - timer bit on timer expiry
// - channel change on control/indicate or s/q
// - sync transfer interrupt when enabled
// - extended bit on six minor causes
// - status read clears all but two bits
// - write-only mask at 0x20, reset zero
// - masked bits hidden but kept pending
// - extended/channel bits shown, masked from pin
// - controller status at 0x21, reset 0x48
`default_nettype none

package hist_pkg;

	localparam int DATA_W     = 8;
	localparam int FIFO_DEPTH = 32;
	localparam int PTR_W      = 5;
	localparam int CNT_W      = 6;
	localparam int EXT_N      = 6;
	localparam logic [CNT_W-1:0] POOL_FULL = 6'h20;

	// printed offsets are word indices; byte address is index times four
	localparam logic [7:0] IDX_WINDOW_LAST = 8'h1f;
	localparam logic [7:0] IDX_IRQ_STATUS  = 8'h20;
	localparam logic [7:0] IDX_CTRL_STATUS = 8'h21;
	localparam logic [7:0] IDX_TX_COMMAND  = 8'h24;
	localparam logic [7:0] IDX_CH0_RECEIVE = 8'h25;
	localparam logic [7:0] IDX_SYNC_CTRL   = 8'h26;
	localparam logic [7:0] IDX_EXT_CAUSE   = 8'h27;

	// interrupt status / mask bit positions
	localparam int BIT_RX_MSG_END   = 7;
	localparam int BIT_RX_POOL_FULL = 6;
	localparam int BIT_REMOTE_CHG   = 5;
	localparam int BIT_TX_POOL_RDY  = 4;
	localparam int BIT_TIMER        = 3;
	localparam int BIT_CHANNEL_CHG  = 2;
	localparam int BIT_SYNC         = 1;
	localparam int BIT_EXTENDED     = 0;
	localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;
	localparam logic [7:0] IRQ_MASK_RESET   = 8'h00;
	localparam logic [7:0] ALWAYS_SHOWN     = 8'h05;
	localparam logic [7:0] CLEAR_ON_READ    = 8'hfa;

	// controller status bit positions
	localparam int BIT_TX_OVERFLOW   = 7;
	localparam int BIT_TX_WRITABLE   = 6;
	localparam int BIT_LOCAL_NR      = 5;
	localparam int BIT_REMOTE_NR     = 4;
	localparam int BIT_MSG_BUF_READY = 3;
	localparam int BIT_MON1_ACTIVE   = 2;
	localparam int BIT_BCH_VALID     = 1;
	localparam int BIT_MON0_ACTIVE   = 0;
	localparam logic [7:0] CTRL_STATUS_RESET = 8'h48;

	// transmit command bits and sync enable bit
	localparam int CMD_TRANSPARENT = 2;
	localparam int CMD_INFO_FRAME  = 1;
	localparam int CMD_MSG_END     = 0;
	localparam int SYNC_ENABLE_BIT = 0;

	typedef enum logic [1:0] {
		TX_IDLE,
		TX_SENDING,
		TX_WAIT_ACK
	} hist_tx_state_t;

endpackage

`default_nettype wire

// file: core/hist_pool_if.sv
// carrier between the register core and the transmit pool
`default_nettype none

interface hist_pool_if;
	logic                        wr_en;
	logic [hist_pkg::DATA_W-1:0] wr_data;
	logic                        rd_en;
	logic                        release_pool;
	logic [hist_pkg::DATA_W-1:0] rd_data;
	logic                        writable;
	logic                        overflow;

	modport core (output wr_en, output wr_data, output rd_en, output release_pool,
		input rd_data, input writable, input overflow);
	modport pool (input wr_en, input wr_data, input rd_en, input release_pool,
		output rd_data, output writable, output overflow);
endinterface

`default_nettype wire

// file: core/hist_tx_pool.sv
// transmit fifo storage with auto-incrementing pointers and pool overflow tracking
`default_nettype none

module hist_tx_pool (
	input  wire logic clk,
	input  wire logic rst_sync_n,
	hist_pool_if.pool p
);

	typedef struct packed {
		logic [hist_pkg::FIFO_DEPTH-1:0][hist_pkg::DATA_W-1:0] mem;
		logic [hist_pkg::PTR_W-1:0]                            wr_ptr;
		logic [hist_pkg::PTR_W-1:0]                            rd_ptr;
		logic [hist_pkg::CNT_W-1:0]                            count;
		logic [hist_pkg::CNT_W-1:0]                            pool_cnt;
		logic                                                  overflow;
		logic [hist_pkg::DATA_W-1:0]                           rd_data;
	} hist_pool_state_t;

	hist_pool_state_t s_reg;
	hist_pool_state_t s_next;

	always_comb
	begin
		s_next = s_reg;
		if (p.release_pool)
		begin
			s_next.pool_cnt = '0;
			s_next.overflow = 1'b0;
		end
		if (p.rd_en && s_reg.count != '0)
		begin
			s_next.rd_data = s_reg.mem[s_reg.rd_ptr];
			s_next.rd_ptr  = s_reg.rd_ptr + 1'b1;
			s_next.count   = s_reg.count - 1'b1;
		end
		if (p.wr_en)
		begin
			s_next.mem[s_reg.wr_ptr] = p.wr_data;
			s_next.wr_ptr            = s_reg.wr_ptr + 1'b1;
			// a 33rd byte in one pool still lands, but the host is told
			if (s_next.pool_cnt == hist_pkg::POOL_FULL)
				s_next.overflow = 1'b1;
			else
				s_next.pool_cnt = s_next.pool_cnt + 1'b1;
			// full fifo: oldest byte is overwritten, so the reader skips it
			if (s_next.count == hist_pkg::POOL_FULL)
				s_next.rd_ptr = s_next.rd_ptr + 1'b1;
			else
				s_next.count = s_next.count + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign p.rd_data  = s_reg.rd_data;
	assign p.writable = s_reg.pool_cnt < hist_pkg::POOL_FULL;
	assign p.overflow = s_reg.overflow;

endmodule

`default_nettype wire

// file: core/hist_core.sv
// apb register core: interrupt status, mask, controller status and transmit window
`default_nettype none

module hist_core (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       auto_mode,
	input  wire logic                       te_mode,
	input  wire logic                       rx_msg_end_pulse,
	input  wire logic                       rx_pool_full_pulse,
	input  wire logic                       rx_sframe_pulse,
	input  wire logic                       rx_sframe_not_ready,
	input  wire logic                       tx_pool_empty_pulse,
	input  wire logic                       tx_frame_done_pulse,
	input  wire logic                       tx_ack_pulse,
	input  wire logic                       timer_expired_pulse,
	input  wire logic                       ch0_change_pulse,
	input  wire logic [7:0]                 ch0_value,
	input  wire logic                       ch1_change_pulse,
	input  wire logic                       sq_change_pulse,
	input  wire logic                       sync_frame_pulse,
	input  wire logic [hist_pkg::EXT_N-1:0] ext_event,
	input  wire logic                       local_not_ready,
	input  wire logic                       msg_buffer_ready,
	input  wire logic                       monitor_ch0_active,
	input  wire logic                       monitor_ch1_active,
	input  wire logic                       bchannel_valid,
	input  wire logic                       tx_rd_en,
	output logic      [7:0]                 tx_data,
	output logic                            tx_start,
	output logic                            tx_info_frame,
	output logic                            tx_msg_end,
	output logic                            irq
);

	typedef struct packed {
		logic [7:0]                 interrupt_status;
		logic [7:0]                 mask;
		logic [7:0]                 controller_status;
		logic [hist_pkg::EXT_N-1:0] ext_cause;
		logic [7:0]                 ch0_rx;
		logic                       sync_en;
		hist_pkg::hist_tx_state_t   tx_state;
		logic                       tx_iframe;
		logic                       tx_me;
		logic                       tx_start;
		logic [31:0]                prdata;
		logic                       pready;
		logic                       pslverr;
		logic                       irq;
	} hist_core_state_t;

	hist_core_state_t s_reg;
	hist_core_state_t s_next;

	logic [1:0]  rst_pipe_reg;
	logic        rst_sync_n;
	logic        setup;
	logic        access;
	logic        acc_write;
	logic        acc_read;
	logic [7:0]  idx;
	logic [7:0]  visible;
	logic        xpr_event;

	hist_pool_if pool_bus ();

	hist_tx_pool u_pool (
		.clk        (clk),
		.rst_sync_n (rst_sync_n),
		.p          (pool_bus.pool)
	);

	function automatic logic [7:0] reg_index(input logic [11:0] addr);
		reg_index = addr[9:2];
	endfunction

	function automatic logic is_mapped(input logic [11:0] addr);
		logic [7:0] i;
		i = reg_index(addr);
		is_mapped = (addr[11:10] == 2'h0) && (addr[1:0] == 2'h0) &&
			(i <= hist_pkg::IDX_CTRL_STATUS ||
			(i >= hist_pkg::IDX_TX_COMMAND && i <= hist_pkg::IDX_EXT_CAUSE));
	endfunction

	// asynchronous assert, release through two flip-flops
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_pipe_reg <= 2'h0;
		else
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
	end
	assign rst_sync_n = rst_pipe_reg[1];

	assign setup     = psel && !penable;
	assign access    = psel && penable && s_reg.pready;
	assign acc_write = access && pwrite && is_mapped(paddr);
	assign acc_read  = access && !pwrite && is_mapped(paddr);
	assign idx       = reg_index(paddr);

	// masked bits stay pending and hidden; two bits always show
	assign visible = s_reg.interrupt_status & (~s_reg.mask | hist_pkg::ALWAYS_SHOWN);

	assign pool_bus.wr_en        = acc_write && idx <= hist_pkg::IDX_WINDOW_LAST;
	assign pool_bus.wr_data      = pwdata[7:0];
	assign pool_bus.rd_en        = tx_rd_en;
	assign pool_bus.release_pool = xpr_event;

	always_comb
	begin
		s_next    = s_reg;
		xpr_event = 1'b0;

		// apb: read data is caught in setup so the answer comes from a flop
		s_next.pready  = setup;
		s_next.pslverr = setup && !is_mapped(paddr);
		if (setup)
		begin
			s_next.prdata = 32'h0;
			if (is_mapped(paddr))
			begin
				case (idx)
					hist_pkg::IDX_IRQ_STATUS:  s_next.prdata[7:0] = visible;
					hist_pkg::IDX_CTRL_STATUS: s_next.prdata[7:0] = s_reg.controller_status;
					hist_pkg::IDX_CH0_RECEIVE: s_next.prdata[7:0] = s_reg.ch0_rx;
					hist_pkg::IDX_SYNC_CTRL:   s_next.prdata[hist_pkg::SYNC_ENABLE_BIT] = s_reg.sync_en;
					hist_pkg::IDX_EXT_CAUSE:   s_next.prdata[hist_pkg::EXT_N-1:0] = s_reg.ext_cause;
					default:                   s_next.prdata = 32'h0;
				endcase
			end
		end

		// a status read clears only what the host actually saw, so late events survive
		if (acc_read)
		begin
			case (idx)
				hist_pkg::IDX_IRQ_STATUS:
					s_next.interrupt_status = s_reg.interrupt_status & ~(s_reg.prdata[7:0] & hist_pkg::CLEAR_ON_READ);
				hist_pkg::IDX_CH0_RECEIVE:
					s_next.interrupt_status[hist_pkg::BIT_CHANNEL_CHG] = 1'b0;
				hist_pkg::IDX_EXT_CAUSE:
				begin
					s_next.interrupt_status[hist_pkg::BIT_EXTENDED] = 1'b0;
					s_next.ext_cause = s_reg.ext_cause & ~s_reg.prdata[hist_pkg::EXT_N-1:0];
				end
				default:
					s_next.interrupt_status = s_reg.interrupt_status;
			endcase
		end

		s_next.tx_start = 1'b0;
		if (acc_write)
		begin
			case (idx)
				hist_pkg::IDX_IRQ_STATUS:
					s_next.mask = pwdata[7:0];
				hist_pkg::IDX_SYNC_CTRL:
					s_next.sync_en = pwdata[hist_pkg::SYNC_ENABLE_BIT];
				hist_pkg::IDX_TX_COMMAND:
				begin
					// info frames exist only in auto-mode; a busy transmitter ignores commands
					if (s_reg.tx_state == hist_pkg::TX_IDLE &&
						(pwdata[hist_pkg::CMD_TRANSPARENT] || (pwdata[hist_pkg::CMD_INFO_FRAME] && auto_mode)))
					begin
						s_next.tx_state  = hist_pkg::TX_SENDING;
						s_next.tx_iframe = !pwdata[hist_pkg::CMD_TRANSPARENT];
						s_next.tx_me     = pwdata[hist_pkg::CMD_MSG_END];
						s_next.tx_start  = 1'b1;
					end
				end
				default:
					s_next.mask = s_reg.mask;
			endcase
		end

		// transmit sequencing towards pool ready
		case (s_reg.tx_state)
			hist_pkg::TX_IDLE:
				s_next.tx_state = s_next.tx_state;
			hist_pkg::TX_SENDING:
			begin
				if (tx_pool_empty_pulse && !s_reg.tx_me)
				begin
					xpr_event       = 1'b1;
					s_next.tx_state = hist_pkg::TX_IDLE;
				end
				else if (tx_frame_done_pulse && s_reg.tx_me)
				begin
					xpr_event       = !s_reg.tx_iframe;
					s_next.tx_state = s_reg.tx_iframe ? hist_pkg::TX_WAIT_ACK : hist_pkg::TX_IDLE;
				end
			end
			hist_pkg::TX_WAIT_ACK:
			begin
				if (tx_ack_pulse)
				begin
					xpr_event       = 1'b1;
					s_next.tx_state = hist_pkg::TX_IDLE;
				end
			end
			default:
				s_next.tx_state = hist_pkg::TX_IDLE;
		endcase

		// event sets come last so a set in the clearing cycle wins
		if (rx_msg_end_pulse)
			s_next.interrupt_status[hist_pkg::BIT_RX_MSG_END] = 1'b1;
		if (rx_pool_full_pulse)
			s_next.interrupt_status[hist_pkg::BIT_RX_POOL_FULL] = 1'b1;
		if (auto_mode && rx_sframe_pulse && rx_sframe_not_ready != s_reg.controller_status[hist_pkg::BIT_REMOTE_NR])
			s_next.interrupt_status[hist_pkg::BIT_REMOTE_CHG] = 1'b1;
		if (xpr_event)
			s_next.interrupt_status[hist_pkg::BIT_TX_POOL_RDY] = 1'b1;
		if (timer_expired_pulse)
			s_next.interrupt_status[hist_pkg::BIT_TIMER] = 1'b1;
		if (ch0_change_pulse || (ch1_change_pulse && te_mode) || sq_change_pulse)
			s_next.interrupt_status[hist_pkg::BIT_CHANNEL_CHG] = 1'b1;
		if (ch0_change_pulse)
			s_next.ch0_rx = ch0_value;
		if (sync_frame_pulse && s_reg.sync_en)
			s_next.interrupt_status[hist_pkg::BIT_SYNC] = 1'b1;
		if (ext_event != '0)
			s_next.interrupt_status[hist_pkg::BIT_EXTENDED] = 1'b1;
		s_next.ext_cause = s_next.ext_cause | ext_event;

		// controller status mirrors live state each cycle, but remote not ready changes only on an auto-mode s-frame
		s_next.controller_status[hist_pkg::BIT_TX_OVERFLOW]   = pool_bus.overflow;
		s_next.controller_status[hist_pkg::BIT_TX_WRITABLE]   = pool_bus.writable && s_reg.tx_state == hist_pkg::TX_IDLE;
		s_next.controller_status[hist_pkg::BIT_LOCAL_NR]      = auto_mode && local_not_ready;
		if (auto_mode && rx_sframe_pulse)
			s_next.controller_status[hist_pkg::BIT_REMOTE_NR] = rx_sframe_not_ready;
		s_next.controller_status[hist_pkg::BIT_MSG_BUF_READY] = msg_buffer_ready;
		s_next.controller_status[hist_pkg::BIT_MON1_ACTIVE]   = monitor_ch1_active;
		s_next.controller_status[hist_pkg::BIT_BCH_VALID]     = bchannel_valid;
		s_next.controller_status[hist_pkg::BIT_MON0_ACTIVE]   = monitor_ch0_active;

		s_next.irq = |(s_next.interrupt_status & ~s_next.mask);
	end

	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			s_reg          <= '0;
			s_reg.interrupt_status     <= hist_pkg::IRQ_STATUS_RESET;
			s_reg.mask     <= hist_pkg::IRQ_MASK_RESET;
			s_reg.controller_status     <= hist_pkg::CTRL_STATUS_RESET;
			s_reg.tx_state <= hist_pkg::TX_IDLE;
		end
		else
			s_reg <= s_next;
	end

	assign prdata        = s_reg.prdata;
	assign pready        = s_reg.pready;
	assign pslverr       = s_reg.pslverr;
	assign tx_data       = pool_bus.rd_data;
	assign tx_start      = s_reg.tx_start;
	assign tx_info_frame = s_reg.tx_iframe;
	assign tx_msg_end    = s_reg.tx_me;
	assign irq           = s_reg.irq;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_sync_n);

	sequence seq_status_read;
		setup && !pwrite && is_mapped(paddr) && idx == hist_pkg::IDX_IRQ_STATUS;
	endsequence

	sequence seq_answer;
		pready ##1 !pready;
	endsequence

	chk_window_write: assert property (access && pwrite && paddr[11:7] == 5'h0 && paddr[1:0] == 2'h0
		|-> pool_bus.wr_en && pool_bus.wr_data == pwdata[7:0])
		else $error("window write did not reach the pool");

	chk_apb_answer: assert property (setup |=> seq_answer)
		else $error("apb answer not one cycle after setup");

	chk_status_clear: assert property (seq_status_read ##1 (penable && prdata[hist_pkg::BIT_RX_MSG_END]
		&& !rx_msg_end_pulse) |=> !s_reg.interrupt_status[hist_pkg::BIT_RX_MSG_END])
		else $error("status read left message end set");

	chk_keep_extended: assert property (seq_status_read ##1 (penable && s_reg.interrupt_status[hist_pkg::BIT_EXTENDED])
		|=> s_reg.interrupt_status[hist_pkg::BIT_EXTENDED])
		else $error("status read cleared the extended bit");

	chk_mask_hidden: assert property (seq_status_read and
		(s_reg.mask[hist_pkg::BIT_TIMER] && s_reg.interrupt_status[hist_pkg::BIT_TIMER])
		|=> !prdata[hist_pkg::BIT_TIMER] ##1 s_reg.interrupt_status[hist_pkg::BIT_TIMER])
		else $error("masked timer bit shown or lost");

	chk_irq_gating: assert property (irq == |(s_reg.interrupt_status & ~s_reg.mask))
		else $error("interrupt pin disagrees with masked status");

	chk_rme_set: assert property (rx_msg_end_pulse |=> s_reg.interrupt_status[hist_pkg::BIT_RX_MSG_END])
		else $error("message end event lost");

	chk_rsc_auto: assert property ($rose(s_reg.interrupt_status[hist_pkg::BIT_REMOTE_CHG]) |-> $past(auto_mode))
		else $error("remote state change outside auto-mode");

	chk_xpr_ack: assert property (s_reg.tx_state == hist_pkg::TX_WAIT_ACK && tx_ack_pulse
		|=> s_reg.interrupt_status[hist_pkg::BIT_TX_POOL_RDY] && s_reg.tx_state == hist_pkg::TX_IDLE)
		else $error("acknowledged info frame gave no pool ready");

	chk_ext_set: assert property (ext_event != '0 |=> s_reg.interrupt_status[hist_pkg::BIT_EXTENDED]
		&& s_reg.ext_cause != '0)
		else $error("extended cause not recorded");

	chk_sync_gate: assert property (sync_frame_pulse && !s_reg.sync_en && !s_reg.interrupt_status[hist_pkg::BIT_SYNC]
		|=> !s_reg.interrupt_status[hist_pkg::BIT_SYNC])
		else $error("sync interrupt while disabled");

endmodule

`default_nettype wire

// file: verification/hist_tx_model.sv
// transmitter stand-in: pops the transmit pool and reports pool, frame and acknowledge events
`default_nettype none

module hist_tx_model (
	input  wire logic       clk,
	input  wire logic       tx_start,
	input  wire logic       tx_info_frame,
	input  wire logic       tx_msg_end,
	input  wire logic [7:0] tx_data,
	input  wire logic [5:0] n_pop,
	input  wire logic [2:0] delay,
	output logic            tx_rd_en,
	output logic            pool_empty,
	output logic            frame_done,
	output logic            ack
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] mem [0:31];
	logic       info;
	logic       last;

	initial
	begin
		tx_rd_en = 1'b0;
		pool_empty = 1'b0;
		frame_done = 1'b0;
		ack = 1'b0;
	end

	// delay lets the bench make the transmitter prompt or slow
	always
	begin
		@(posedge clk);
		if (tx_start === 1'b1)
		begin
			info = tx_info_frame;
			last = tx_msg_end;
			repeat (delay) @(posedge clk);
			for (int k = 0; k < n_pop; k++)
			begin
				tx_rd_en <= 1'b1;
				@(posedge clk);
				tx_rd_en <= 1'b0;
				@(posedge clk);
				mem[k] = tx_data;
			end
			frame_done <= last;
			pool_empty <= !last;
			@(posedge clk);
			frame_done <= 1'b0;
			pool_empty <= 1'b0;
			// remote acknowledge only follows a finished info frame
			if (last && info)
			begin
				repeat (delay) @(posedge clk);
				ack <= 1'b1;
				@(posedge clk);
				ack <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

// file: verification/test_hdlc_irq_status_txfifo.sv
// self-checking bench of the interrupt, status and transmit window block
`default_nettype none

module test_hdlc_irq_status_txfifo;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic        pready, pslverr, irq, tx_start, tx_info_frame, tx_msg_end, tx_rd_en, perr;
	logic        pool_empty, frame_done, ack, rnr = 1'b0;
	logic [7:0]  tx_data, ch0_value = '0, ev = '0, lv = 8'h08;
	logic [5:0]  ext_event = '0, n_pop = '0, x;
	logic [2:0]  delay = '0;
	logic [7:0]  exp_b [0:31];
	integer      seed = 32'hf26c, miscompares = 0, n_tests = 0, cycles = 0;
	int          src [4] = '{7, 6, 3, 1};

	hist_core i_hist_core (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.auto_mode(lv[5]), .te_mode(lv[6]), .rx_msg_end_pulse(ev[7]), .rx_pool_full_pulse(ev[6]),
		.rx_sframe_pulse(ev[5]), .rx_sframe_not_ready(lv[7]), .tx_pool_empty_pulse(pool_empty),
		.tx_frame_done_pulse(frame_done), .tx_ack_pulse(ack), .timer_expired_pulse(ev[3]),
		.ch0_change_pulse(ev[2]), .ch0_value(ch0_value), .ch1_change_pulse(ev[4]), .sq_change_pulse(ev[0]),
		.sync_frame_pulse(ev[1]), .ext_event(ext_event), .local_not_ready(lv[4]), .msg_buffer_ready(lv[3]),
		.monitor_ch0_active(lv[0]), .monitor_ch1_active(lv[2]), .bchannel_valid(lv[1]),
		.tx_rd_en(tx_rd_en), .tx_data(tx_data), .tx_start(tx_start), .tx_info_frame(tx_info_frame),
		.tx_msg_end(tx_msg_end), .irq(irq));

	hist_tx_model i_hist_tx_model (.clk(clk), .tx_start(tx_start), .tx_info_frame(tx_info_frame),
		.tx_msg_end(tx_msg_end), .tx_data(tx_data), .n_pop(n_pop), .delay(delay), .tx_rd_en(tx_rd_en),
		.pool_empty(pool_empty), .frame_done(frame_done), .ack(ack));

	always #2 clk = ~clk;

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// entered just after a rising edge, leaves just after one
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(r, exp);
	endtask

	task automatic pulse(input logic [7:0] e, input logic [5:0] c);
		ev <= e;
		ext_event <= c;
		@(posedge clk);
		ev <= '0;
		ext_event <= '0;
		repeat (2) @(posedge clk);
	endtask

	function automatic logic [31:0] ctrl(input logic ovf, input logic wrb);
		return {24'h0, ovf, wrb, lv[4] & lv[5], rnr, lv[3], lv[2], lv[1], lv[0]};
	endfunction

	task automatic tx_run(input logic [7:0] cmd, input logic [5:0] n);
		n_pop <= n;
		delay <= 3'($random(seed));
		for (int k = 0; k < n; k++)
		begin
			exp_b[k] = 8'($random(seed));
			apb(1'b1, 8'($random(seed)) & hist_pkg::IDX_WINDOW_LAST, {24'h0, exp_b[k]});
		end
		apb(1'b1, hist_pkg::IDX_TX_COMMAND, {24'h0, cmd});
		chk({30'h0, tx_info_frame, tx_msg_end}, {30'h0, cmd[1] & ~cmd[2], cmd[0]});
		r = '0;
		for (int t = 0; t < 80 && r[4] !== 1'b1; t++)
			apb(1'b0, hist_pkg::IDX_IRQ_STATUS, 32'h0);
		chk(r & 32'h10, 32'h10);
		for (int k = 0; k < n; k++)
			chk({24'h0, i_hist_tx_model.mem[k]}, {24'h0, exp_b[k]});
	endtask

	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(hist_pkg::IDX_IRQ_STATUS, 32'h0);
		rd(hist_pkg::IDX_CTRL_STATUS, 32'h48);
		rd(8'h05, 32'h0);
		apb(1'b0, 8'h28, 32'h0);
		chk({31'h0, perr}, 32'h1);
		repeat (6)
		begin
			lv <= {2'b00, 6'($random(seed))};
			repeat (2) @(posedge clk);
			rd(hist_pkg::IDX_CTRL_STATUS, ctrl(1'b0, 1'b1));
		end
		apb(1'b1, hist_pkg::IDX_SYNC_CTRL, 32'h1);
		for (int i = 0; i < 4; i++)
		begin
			pulse(8'h1 << src[i], 6'h0);
			chk({31'h0, irq}, 32'h1);
			rd(hist_pkg::IDX_IRQ_STATUS, 32'h1 << src[i]);
			@(posedge clk);
			chk({31'h0, irq}, 32'h0);
			rd(hist_pkg::IDX_IRQ_STATUS, 32'h0);
		end
		pulse(8'hca, 6'h0);
		rd(hist_pkg::IDX_IRQ_STATUS, 32'hca);
		apb(1'b1, hist_pkg::IDX_IRQ_STATUS, 32'hff);
		x = 6'($random(seed)) | 6'h01;
		ch0_value <= 8'($random(seed));
		pulse(8'h8c, x);
		chk({31'h0, irq}, 32'h0);
		rd(hist_pkg::IDX_IRQ_STATUS, 32'h05);
		rd(hist_pkg::IDX_IRQ_STATUS, 32'h05);
		apb(1'b1, hist_pkg::IDX_IRQ_STATUS, 32'h0);
		@(posedge clk);
		chk({31'h0, irq}, 32'h1);
		rd(hist_pkg::IDX_IRQ_STATUS, 32'h8d);
		rd(hist_pkg::IDX_CH0_RECEIVE, {24'h0, ch0_value});
		rd(hist_pkg::IDX_EXT_CAUSE, {26'h0, x});
		rd(hist_pkg::IDX_IRQ_STATUS, 32'h0);
		// channel 1 change counts only in terminal mode
		lv[6] <= 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			pulse(i ? 8'h01 : 8'h10, 6'h0);
			rd(hist_pkg::IDX_IRQ_STATUS, 32'h04);
			rd(hist_pkg::IDX_CH0_RECEIVE, {24'h0, ch0_value});
			rd(hist_pkg::IDX_IRQ_STATUS, 32'h0);
		end
		lv[5] <= 1'b1;
		lv[7] <= 1'b1;
		pulse(8'h20, 6'h0);
		rnr = 1'b1;
		rd(hist_pkg::IDX_IRQ_STATUS, 32'h20);
		rd(hist_pkg::IDX_CTRL_STATUS, ctrl(1'b0, 1'b1));
		pulse(8'h20, 6'h0);
		rd(hist_pkg::IDX_IRQ_STATUS, 32'h0);
		lv[5] <= 1'b0;
		lv[7] <= 1'b0;
		pulse(8'h20, 6'h0);
		rd(hist_pkg::IDX_IRQ_STATUS, 32'h0);
		rd(hist_pkg::IDX_CTRL_STATUS, ctrl(1'b0, 1'b1));
		tx_run(8'h05, 6'd32);
		apb(1'b0, hist_pkg::IDX_CTRL_STATUS, 32'h0);
		chk(r & 32'hc0, 32'h40);
		lv[5] <= 1'b1;
		tx_run(8'h03, 6'd1 + 6'($random(seed) & 15));
		tx_run(8'h04, 6'd5);
		// one byte past a full pool must flag the overflow
		for (int k = 0; k < 33; k++)
			apb(1'b1, 8'(k) & hist_pkg::IDX_WINDOW_LAST, 32'($random(seed)) & 32'hff);
		apb(1'b0, hist_pkg::IDX_CTRL_STATUS, 32'h0);
		chk(r & 32'hc0, 32'h80);
		end_of_test();
	end
endmodule

`default_nettype wire
